// ===== hw/nvmc_ctrl.sv
/*
  Nonvolatile array control and pll settle timing, register side.
  Assumes a serial engine that presents one register access per cycle
  on regReq and pulses txnEnd at the end of each serial transaction.
*/
// Behaviour
// - closed-loop settle code picks 150/300/500/2000 us, resets to 2
// - vco settle code picks 20/400/4000/10000 us, resets to 1
// - read-only byte shows the stored crc fetched from the array
// - counter increments after each erase/program cycle, kept in the array
// - counter reloads after reset, after a load, after each cycle
// - counter saturates at 255
// - copy bit copies live registers into the sram, clears when done
// - crc error flag sets on a mismatch while loading from the array
// - auto crc enable, reset one, computes stored crc on program
// - array loads into registers after reset and on load bit, self clears
// - register reads are not served while a load runs
// - busy flag stays high through erase/program, array access refused
// - erase starts only if previous transaction wrote the unlock key
// - erase lasts about 115 ms with busy high
// - program starts only if previous transaction wrote the unlock key
// - erase and program together run erase then program
// - program lasts about 115 ms with busy high
`timescale 1ns/10ps

module nvmc_ctrl
  import nvmc_pkg::*;
#(
  parameter int DEPTH = `NVMC_NVM_DEPTH,
  parameter int CYCLES_PER_US = `NVMC_CYCLES_PER_US,
  parameter int ERASE_US = `NVMC_ERASE_US,
  parameter int PROG_US = `NVMC_PROG_US,
  parameter int VCO_US0 = `NVMC_VCO_US0,
  parameter int VCO_US1 = `NVMC_VCO_US1,
  parameter int VCO_US2 = `NVMC_VCO_US2,
  parameter int VCO_US3 = `NVMC_VCO_US3,
  parameter int CLSD_US0 = `NVMC_CLSD_US0,
  parameter int CLSD_US1 = `NVMC_CLSD_US1,
  parameter int CLSD_US2 = `NVMC_CLSD_US2,
  parameter int CLSD_US3 = `NVMC_CLSD_US3,
  // key value arbitrary
  parameter logic [7:0] UNLOCK_KEY = 8'h5A
) (
  input wire logic clk,
  input wire logic rst,
  input nvmc_reg_req_s regReq,
  input wire logic txnEnd,
  output logic regRdReady,
  output logic regRdValid,
  output logic [7:0] regRdData,
  output nvmc_cfg_byte_s cfgLoad,
  output logic [$clog2(DEPTH)-1:0] liveAddr,
  input wire logic [7:0] liveData,
  input wire logic pllCalStart,
  output logic pllSettling,
  output logic pllSettleDone,
  output logic [1:0] vcoSettleSel,
  output logic [1:0] closedLoopSettleSel,
  output logic arrayBusy
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] IDX_PLL = AW'(DEPTH - 3);
  localparam logic [AW-1:0] IDX_CNT = AW'(DEPTH - 2);
  localparam logic [AW-1:0] IDX_CRC = AW'(DEPTH - 1);

  if (DEPTH < 4 || DEPTH != (1 << AW) || AW > 5 || CYCLES_PER_US < 1 || CYCLES_PER_US > 128
      || ERASE_US >= (1 << 17) || PROG_US >= (1 << 17)) begin : g_chk
    $error("nvmc_ctrl: unsupported parameter values");
  end

  function automatic logic [7:0] nvmcCrc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `NVMC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [16:0] nvmcPick(input logic [1:0] sel, input int a, input int b,
                                           input int c, input int d);
    case (sel)
      2'h0: nvmcPick = 17'(a);
      2'h1: nvmcPick = 17'(b);
      2'h2: nvmcPick = 17'(c);
      default: nvmcPick = 17'(d);
    endcase
  endfunction

  nvmc_state_e state_q;
  logic [AW:0] ptr_q;
  logic rdV_q;
  logic [AW-1:0] rdIdx_q;
  logic [7:0] crc_q;
  logic [3:0] pllCfg_q;
  logic [7:0] count_q;
  logic [7:0] storedCrc_q;
  logic crcErr_q;
  logic autoCrc_q;
  logic opProg_q;
  logic unlockSeen_q;
  logic unlockOk_q;
  logic [16:0] waitUs_q;
  logic [6:0] tickCnt_q;
  logic usTick;
  logic [1:0] settlePhase_q;
  logic [16:0] settleUs_q;
  logic [AW-1:0] eeAddr, srAddr;
  logic eeWe, srWe;
  logic [7:0] eeWd, srWd, eeRd, srRd;
  logic wrCtl, walkEnd;
  logic [7:0] cntNext;

  assign wrCtl = regReq.wr && regReq.addr == `NVMC_OFS_CTL;
  assign walkEnd = ptr_q[AW] && !rdV_q;
  // saturating increment
  // stop at 255
  assign cntNext = (count_q == `NVMC_CNT_MAX) ? count_q : count_q + 8'h01;
  assign liveAddr = ptr_q[AW-1:0];
  assign arrayBusy = state_q inside {NVMC_ERASE, NVMC_EWAIT, NVMC_PROG, NVMC_PWAIT,
                                     NVMC_RELOAD};
  assign regRdReady = state_q != NVMC_LOAD;
  assign vcoSettleSel = pllCfg_q[`NVMC_VCO_LSB +: 2];
  assign closedLoopSettleSel = pllCfg_q[`NVMC_CLSD_LSB +: 2];

  //////////////////////////////////////////////////////////////////////////////
  nvmc_mem #(.DW(8), .DEPTH(DEPTH)) u_eeprom (
    .clk(clk),
    .rst(rst),
    .wrEn(eeWe),
    .addr(eeAddr),
    .wrData(eeWd),
    .rdData(eeRd)
  );

  nvmc_mem #(.DW(8), .DEPTH(DEPTH)) u_sram (
    .clk(clk),
    .rst(rst),
    .wrEn(srWe),
    .addr(srAddr),
    .wrData(srWd),
    .rdData(srRd)
  );

  // array port steering per state
  always_comb begin
    eeAddr = ptr_q[AW-1:0];
    eeWe = 1'b0;
    eeWd = 8'h00;
    srAddr = ptr_q[AW-1:0];
    srWe = 1'b0;
    srWd = 8'h00;
    case (state_q)
      NVMC_LOAD: begin
        // sram mirrors the array as it streams out
        srAddr = rdIdx_q;
        srWe = rdV_q;
        srWd = eeRd;
      end
      NVMC_COPY: begin
        srWe = !ptr_q[AW];
        if (ptr_q[AW-1:0] == IDX_PLL) begin
          srWd = {4'h0, pllCfg_q};
        end else if (ptr_q[AW-1:0] == IDX_CNT) begin
          srWd = count_q;
        end else if (ptr_q[AW-1:0] == IDX_CRC) begin
          srWd = storedCrc_q;
        end else begin
          srWd = liveData;
        end
      end
      NVMC_ERASE: begin
        // counter byte survives erase
        eeWe = !ptr_q[AW] && ptr_q[AW-1:0] != IDX_CNT;
      end
      NVMC_PROG: begin
        eeAddr = rdIdx_q;
        eeWe = rdV_q && rdIdx_q != IDX_CNT;
        eeWd = (rdIdx_q == IDX_CRC && autoCrc_q) ? crc_q : srRd;
      end
      NVMC_RELOAD: begin
        eeAddr = IDX_CNT;
        eeWe = ptr_q == '0;
        eeWd = cntNext;
      end
      default: begin
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // microsecond tick for all long waits
  always_ff @(posedge clk) begin
    if (rst || usTick) begin
      tickCnt_q <= 7'h00;
    end else begin
      tickCnt_q <= tickCnt_q + 7'h01;
    end
  end
  assign usTick = tickCnt_q == 7'(CYCLES_PER_US - 1);

  // sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= NVMC_LOAD;
      ptr_q <= '0;
      opProg_q <= 1'b0;
      waitUs_q <= 17'h00000;
    end else begin
      case (state_q)
        NVMC_IDLE: begin
          ptr_q <= '0;
          if (wrCtl && (regReq.wdata[`NVMC_CTL_ERASE] || regReq.wdata[`NVMC_CTL_PROG])) begin
            if (unlockOk_q) begin
              opProg_q <= regReq.wdata[`NVMC_CTL_PROG];
              state_q <= regReq.wdata[`NVMC_CTL_ERASE] ? NVMC_ERASE : NVMC_PROG;
            end
          end else if (wrCtl && regReq.wdata[`NVMC_CTL_LOAD]) begin
            state_q <= NVMC_LOAD;
          end else if (wrCtl && regReq.wdata[`NVMC_CTL_COPY]) begin
            state_q <= NVMC_COPY;
          end
        end
        NVMC_LOAD, NVMC_PROG: begin
          if (!ptr_q[AW]) begin
            ptr_q <= ptr_q + 1'b1;
          end else if (walkEnd) begin
            state_q <= (state_q == NVMC_PROG) ? NVMC_PWAIT : NVMC_IDLE;
            waitUs_q <= 17'(PROG_US);
          end
        end
        NVMC_COPY, NVMC_ERASE: begin
          if (!ptr_q[AW]) begin
            ptr_q <= ptr_q + 1'b1;
          end else begin
            state_q <= (state_q == NVMC_ERASE) ? NVMC_EWAIT : NVMC_IDLE;
            waitUs_q <= 17'(ERASE_US);
          end
        end
        NVMC_EWAIT, NVMC_PWAIT: begin
          ptr_q <= '0;
          if (waitUs_q == 17'h00000) begin
            state_q <= (state_q == NVMC_EWAIT && opProg_q) ? NVMC_PROG : NVMC_RELOAD;
          end else if (usTick) begin
            waitUs_q <= waitUs_q - 17'h00001;
          end
        end
        default: begin
          // reload: write count, read it, capture it
          ptr_q <= ptr_q + 1'b1;
          if (ptr_q == (AW+1)'(3)) begin
            state_q <= NVMC_IDLE;
            opProg_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // read pipeline and crc accumulation
  always_ff @(posedge clk) begin
    if (rst) begin
      rdV_q <= 1'b0;
      rdIdx_q <= '0;
      crc_q <= 8'h00;
    end else begin
      rdV_q <= (state_q == NVMC_LOAD || state_q == NVMC_PROG) && !ptr_q[AW];
      rdIdx_q <= ptr_q[AW-1:0];
      if (state_q == NVMC_IDLE || state_q == NVMC_EWAIT) begin
        crc_q <= 8'h00;
      end else if (rdV_q && rdIdx_q <= IDX_PLL) begin
        crc_q <= nvmcCrc8(crc_q, (state_q == NVMC_LOAD) ? eeRd : srRd);
      end
    end
  end

  // live values captured from the array
  always_ff @(posedge clk) begin
    if (rst) begin
      pllCfg_q <= `NVMC_PLLCFG_RST;
      count_q <= `NVMC_CNT_RST;
      storedCrc_q <= `NVMC_SCRC_RST;
      crcErr_q <= 1'b0;
      cfgLoad <= '0;
    end else begin
      cfgLoad.valid <= state_q == NVMC_LOAD && rdV_q;
      cfgLoad.idx <= 5'(rdIdx_q);
      cfgLoad.data <= eeRd;
      if (regReq.wr && regReq.addr == `NVMC_OFS_PLLCFG) begin
        pllCfg_q <= regReq.wdata[3:0];
      end
      if (state_q == NVMC_LOAD && rdV_q) begin
        if (rdIdx_q == IDX_PLL) begin
          pllCfg_q <= eeRd[3:0];
        end
        if (rdIdx_q == IDX_CNT) begin
          count_q <= eeRd;
        end
        if (rdIdx_q == IDX_CRC) begin
          storedCrc_q <= eeRd;
        end
      end
      if (state_q == NVMC_LOAD && walkEnd) begin
        crcErr_q <= crc_q != storedCrc_q;
      end
      if (state_q == NVMC_PROG && rdV_q && rdIdx_q == IDX_CRC) begin
        storedCrc_q <= eeWd;
      end
      if (state_q == NVMC_RELOAD && ptr_q == (AW+1)'(2)) begin
        count_q <= eeRd;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // unlock tracking: only the transaction just before counts
  always_ff @(posedge clk) begin
    if (rst) begin
      unlockSeen_q <= 1'b0;
      unlockOk_q <= 1'b0;
      autoCrc_q <= `NVMC_AUTOCRC_RST;
    end else begin
      if (wrCtl) begin
        autoCrc_q <= regReq.wdata[`NVMC_CTL_AUTOCRC];
      end
      if (txnEnd) begin
        unlockOk_q <= (regReq.wr && regReq.addr == `NVMC_OFS_UNLK)
                      ? (regReq.wdata == UNLOCK_KEY) : unlockSeen_q;
        unlockSeen_q <= 1'b0;
      end else if (regReq.wr && regReq.addr == `NVMC_OFS_UNLK) begin
        unlockSeen_q <= regReq.wdata == UNLOCK_KEY;
      end
    end
  end

  // register read port
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdValid <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      regRdValid <= regReq.rd && regRdReady;
      if (regReq.addr == `NVMC_OFS_PLLCFG) begin
        regRdData <= {4'h0, pllCfg_q};
      end else if (regReq.addr == `NVMC_OFS_SCRC) begin
        regRdData <= storedCrc_q;
      end else if (regReq.addr == `NVMC_OFS_CNT) begin
        regRdData <= count_q;
      end else if (regReq.addr == `NVMC_OFS_CTL) begin
        regRdData <= {1'b0, state_q == NVMC_COPY, crcErr_q, autoCrc_q,
                      state_q == NVMC_LOAD, arrayBusy,
                      state_q == NVMC_ERASE || state_q == NVMC_EWAIT,
                      arrayBusy && opProg_q && state_q != NVMC_RELOAD};
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pll settle: vco wait, then closed-loop wait
  always_ff @(posedge clk) begin
    if (rst) begin
      settlePhase_q <= 2'h0;
      settleUs_q <= 17'h00000;
      pllSettleDone <= 1'b0;
    end else begin
      pllSettleDone <= 1'b0;
      if (pllCalStart) begin
        settlePhase_q <= 2'h1;
        settleUs_q <= nvmcPick(vcoSettleSel, VCO_US0, VCO_US1, VCO_US2, VCO_US3);
      end else if (settlePhase_q != 2'h0) begin
        if (settleUs_q != 17'h00000) begin
          if (usTick) begin
            settleUs_q <= settleUs_q - 17'h00001;
          end
        end else if (settlePhase_q == 2'h1) begin
          settlePhase_q <= 2'h2;
          settleUs_q <= nvmcPick(closedLoopSettleSel, CLSD_US0, CLSD_US1, CLSD_US2,
                                 CLSD_US3);
        end else begin
          settlePhase_q <= 2'h0;
          pllSettleDone <= 1'b1;
        end
      end
    end
  end
  assign pllSettling = settlePhase_q != 2'h0;

endmodule

// ===== hw/nvmc_consts.svh
/*
  Offsets, field positions, reset values and timing figures of the
  nonvolatile control block. Definitions only; included by the package
  and the bench modules.
*/
`ifndef NVMC_CONSTS_SVH
`define NVMC_CONSTS_SVH

// register offsets on the serial register port
`define NVMC_OFS_PLLCFG 7'h2A
`define NVMC_OFS_SCRC 7'h2F
`define NVMC_OFS_CNT 7'h30
`define NVMC_OFS_CTL 7'h31
`define NVMC_OFS_UNLK 7'h38

// settle selector fields
`define NVMC_CLSD_LSB 2
`define NVMC_VCO_LSB 0
`define NVMC_PLLCFG_RST 4'h9

// control register bits
`define NVMC_CTL_COPY 6
`define NVMC_CTL_CRCERR 5
`define NVMC_CTL_AUTOCRC 4
`define NVMC_CTL_LOAD 3
`define NVMC_CTL_BUSY 2
`define NVMC_CTL_ERASE 1
`define NVMC_CTL_PROG 0
`define NVMC_AUTOCRC_RST 1'h1
`define NVMC_SCRC_RST 8'h00
`define NVMC_CNT_RST 8'h00
`define NVMC_CNT_MAX 8'hFF

// array size and crc polynomial
`define NVMC_NVM_DEPTH 32
`define NVMC_CRC_POLY 8'h07

// timing: clock period and microsecond tick
`define NVMC_CLK_NS 10
`define NVMC_US_NS 1000
`define NVMC_CYCLES_PER_US (`NVMC_US_NS / `NVMC_CLK_NS)
`define NVMC_ERASE_MS 115
`define NVMC_PROG_MS 115
`define NVMC_ERASE_US (`NVMC_ERASE_MS * 1000)
`define NVMC_PROG_US (`NVMC_PROG_MS * 1000)

// settle times in microseconds, codes 0..3
`define NVMC_VCO_US0 20
`define NVMC_VCO_US1 400
`define NVMC_VCO_US2 4000
`define NVMC_VCO_US3 10000
`define NVMC_CLSD_US0 150
`define NVMC_CLSD_US1 300
`define NVMC_CLSD_US2 500
`define NVMC_CLSD_US3 2000

`endif

// ===== hw/nvmc_pkg.sv
/*
  Types of the nonvolatile control block.
  Assumes nvmc_consts.svh is on the include path.
*/
`include "nvmc_consts.svh"

package nvmc_pkg;

  typedef enum logic [2:0] {
    NVMC_LOAD = 3'b000,
    NVMC_IDLE = 3'b001,
    NVMC_COPY = 3'b010,
    NVMC_ERASE = 3'b011,
    NVMC_EWAIT = 3'b100,
    NVMC_PROG = 3'b101,
    NVMC_PWAIT = 3'b110,
    NVMC_RELOAD = 3'b111
  } nvmc_state_e;

  // one register access from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } nvmc_reg_req_s;

  // one configuration byte handed to the live registers during a load
  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [7:0] data;
  } nvmc_cfg_byte_s;

endpackage

// ===== hw/nvmc_mem.sv
/*
  Single-port byte memory with registered read data.
  Assumes one clock, synchronous active-high reset for the read register.
*/
`timescale 1ns/10ps

module nvmc_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [DW-1:0] wrData,
  output logic [DW-1:0] rdData
);

  // blank array reads zero, so the wear count starts defined
  logic [DW-1:0] mem [DEPTH] = '{default: '0};

  if (DEPTH < 2 || DW < 1) begin : g_chk
    $error("nvmc_mem: unsupported geometry");
  end

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= mem[addr];
    end
  end

endmodule

// ===== bench/nvmc_ctrl_asserts.sv
/*
  Port checker for nvmc_ctrl, bound to each instance.
  Assumes one clock and the hand-over register port contract.
*/
`timescale 1ns/10ps
`include "nvmc_consts.svh"

module nvmc_ctrl_asserts
  import nvmc_pkg::*;
#(
  parameter int CYCLES_PER_US = 100,
  parameter int ERASE_US = 115000,
  parameter int VCO_US0 = 20,
  parameter int VCO_US1 = 400,
  parameter int VCO_US2 = 4000,
  parameter int VCO_US3 = 10000,
  parameter int CLSD_US0 = 150,
  parameter int CLSD_US1 = 300,
  parameter int CLSD_US2 = 500,
  parameter int CLSD_US3 = 2000,
  parameter logic [7:0] UNLOCK_KEY = 8'h5A
) (
  input wire logic clk,
  input wire logic rst,
  input nvmc_reg_req_s regReq,
  input wire logic txnEnd,
  input wire logic regRdReady,
  input wire logic regRdValid,
  input wire logic pllCalStart,
  input wire logic pllSettling,
  input wire logic pllSettleDone,
  input wire logic [1:0] vcoSettleSel,
  input wire logic [1:0] closedLoopSettleSel,
  input wire logic arrayBusy
);
  localparam int VT [4] = '{VCO_US0, VCO_US1, VCO_US2, VCO_US3};
  localparam int CT [4] = '{CLSD_US0, CLSD_US1, CLSD_US2, CLSD_US3};
  logic keyNow, keyTxn_q, unlocked_q, startWr;
  int busyLen_q, settleLen_q, settleExp;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // key must be written in the transaction before the start write
  assign keyNow = regReq.wr && regReq.addr == `NVMC_OFS_UNLK;
  assign startWr = regReq.wr && regReq.addr == `NVMC_OFS_CTL && regReq.wdata[1:0] != 2'b00
    && !arrayBusy;
  assign settleExp = (VT[vcoSettleSel] + CT[closedLoopSettleSel]) * CYCLES_PER_US;
  always_ff @(posedge clk) begin
    if (rst || txnEnd) keyTxn_q <= 1'b0;
    else if (keyNow) keyTxn_q <= regReq.wdata == UNLOCK_KEY;
  end
  always_ff @(posedge clk) begin
    if (rst) unlocked_q <= 1'b0;
    else if (txnEnd) unlocked_q <= keyNow ? regReq.wdata == UNLOCK_KEY : keyTxn_q;
  end
  always_ff @(posedge clk) begin
    if (rst || !arrayBusy) busyLen_q <= 0;
    else busyLen_q <= busyLen_q + 1;
  end
  always_ff @(posedge clk) begin
    if (rst || pllCalStart) settleLen_q <= 0;
    else settleLen_q <= settleLen_q + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_rd_answer: assert property (regReq.rd && regRdReady |=> regRdValid)
    else $error("read not answered next cycle");
  a_rd_refused: assert property (regReq.rd && !regRdReady |=> !regRdValid)
    else $error("read answered during load");
  a_boot_load: assert property ($fell(rst) |-> !regRdReady [*8])
    else $error("no load after reset");
  a_sel_defaults: assert property ($fell(rst) |-> vcoSettleSel == 2'h1
    && closedLoopSettleSel == 2'h2) else $error("settle selects wrong at reset");
  a_locked_refused: assert property (startWr && !unlocked_q |=> !arrayBusy)
    else $error("locked start ran");
  a_unlock_start: assert property (startWr && unlocked_q && regRdReady |=> arrayBusy)
    else $error("unlocked start ignored");
  a_busy_span: assert property ($fell(arrayBusy) |-> busyLen_q >= ERASE_US * CYCLES_PER_US)
    else $error("busy too short");
  a_settle_span: assert property (pllSettleDone |-> settleLen_q >= settleExp
    && settleLen_q <= settleExp + 6) else $error("settle time off");
  a_settle_start: assert property (pllCalStart && !pllSettling |=> pllSettling)
    else $error("settle did not start");
  a_done_pulse: assert property (pllSettleDone |=> !pllSettleDone)
    else $error("done longer than a cycle");

  c_refused: cover property (regReq.rd && !regRdReady);
  c_settled: cover property (pllSettleDone);
  c_cycle: cover property ($fell(arrayBusy));
endmodule

bind nvmc_ctrl nvmc_ctrl_asserts #(.CYCLES_PER_US(CYCLES_PER_US), .ERASE_US(ERASE_US),
  .VCO_US0(VCO_US0), .VCO_US1(VCO_US1), .VCO_US2(VCO_US2), .VCO_US3(VCO_US3),
  .CLSD_US0(CLSD_US0), .CLSD_US1(CLSD_US1), .CLSD_US2(CLSD_US2), .CLSD_US3(CLSD_US3),
  .UNLOCK_KEY(UNLOCK_KEY)) chk (.clk(clk), .rst(rst), .regReq(regReq), .txnEnd(txnEnd),
  .regRdReady(regRdReady), .regRdValid(regRdValid), .pllCalStart(pllCalStart),
  .pllSettling(pllSettling), .pllSettleDone(pllSettleDone), .vcoSettleSel(vcoSettleSel),
  .closedLoopSettleSel(closedLoopSettleSel), .arrayBusy(arrayBusy));

// ===== bench/nvmc_host_model.sv
/*
  Register host and live register file facing nvmc_ctrl.
  Assumes falling-edge stimulus and one access per transaction.
*/
`timescale 1ns/10ps
`include "nvmc_consts.svh"

module nvmc_host_model
  import nvmc_pkg::*;
#(
  parameter logic [7:0] KEY = 8'h5A
) (
  input wire logic clk,
  output nvmc_reg_req_s regReq,
  output logic txnEnd,
  input wire logic regRdReady,
  input wire logic regRdValid,
  input wire logic [7:0] regRdData,
  input nvmc_cfg_byte_s cfgLoad,
  input wire logic [4:0] liveAddr,
  output logic [7:0] liveData
);
  logic [7:0] live [32];

  initial begin
    regReq = '0;
    txnEnd = 1'b0;
  end
  // copy walk needs the byte at once
  assign liveData = live[liveAddr];
  always @(posedge clk) begin
    if (cfgLoad.valid) live[cfgLoad.idx] <= cfgLoad.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    regReq = {1'b1, 1'b0, a, d};
    txnEnd = 1'b1;
    @(negedge clk);
    regReq = '0;
    txnEnd = 1'b0;
  endtask
  task automatic unlock_and_start(input logic [7:0] ctl);
    wr(`NVMC_OFS_UNLK, KEY);
    wr(`NVMC_OFS_CTL, ctl);
  endtask
  task automatic rd(input logic [6:0] a, input logic hold, output logic [7:0] d,
                    output logic ok);
    int n;
    n = 0;
    @(negedge clk);
    while (hold && regRdReady !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    regReq = {1'b0, 1'b1, a, 8'h00};
    txnEnd = 1'b1;
    @(negedge clk);
    ok = regRdValid;
    d = regRdData;
    regReq = '0;
    txnEnd = 1'b0;
  endtask
endmodule

// ===== bench/tb.sv
/*
  Self-checking bench for nvmc_ctrl with the host model.
  Assumes shortened timing parameters and a blank array that reads zero.
*/
`timescale 1ns/10ps
`include "nvmc_consts.svh"

module tb
  import nvmc_pkg::*;
;
  localparam logic [7:0] KEY = 8'h5A;
  localparam int CPU = 2;
  localparam int XUS = 5;
  localparam int VUS [4] = '{1, 2, 3, 4};
  localparam int CUS [4] = '{5, 6, 7, 8};
  logic clk, rst, txnEnd, regRdReady, regRdValid, pllCalStart, pllSettling, pllSettleDone;
  logic arrayBusy, ok;
  logic [7:0] regRdData, liveData, d;
  logic [4:0] liveAddr;
  logic [1:0] vcoSettleSel, closedLoopSettleSel;
  nvmc_reg_req_s regReq;
  nvmc_cfg_byte_s cfgLoad;
  int failures, nCompared, n;

  nvmc_ctrl #(.CYCLES_PER_US(CPU), .ERASE_US(XUS), .PROG_US(XUS), .VCO_US0(VUS[0]),
    .VCO_US1(VUS[1]), .VCO_US2(VUS[2]), .VCO_US3(VUS[3]), .CLSD_US0(CUS[0]),
    .CLSD_US1(CUS[1]), .CLSD_US2(CUS[2]), .CLSD_US3(CUS[3]), .UNLOCK_KEY(KEY)) DUT (
    .clk(clk), .rst(rst), .regReq(regReq), .txnEnd(txnEnd), .regRdReady(regRdReady),
    .regRdValid(regRdValid), .regRdData(regRdData), .cfgLoad(cfgLoad), .liveAddr(liveAddr),
    .liveData(liveData), .pllCalStart(pllCalStart), .pllSettling(pllSettling),
    .pllSettleDone(pllSettleDone), .vcoSettleSel(vcoSettleSel),
    .closedLoopSettleSel(closedLoopSettleSel), .arrayBusy(arrayBusy));
  nvmc_host_model #(.KEY(KEY)) host (.clk(clk), .regReq(regReq), .txnEnd(txnEnd),
    .regRdReady(regRdReady), .regRdValid(regRdValid), .regRdData(regRdData),
    .cfgLoad(cfgLoad), .liveAddr(liveAddr), .liveData(liveData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rr(input logic [6:0] a);
    host.rd(a, 1'b1, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask
  task automatic wait_idle;
    n = 0;
    while (arrayBusy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, n < 400}, 8'h01);
  endtask
  // stored crc over bytes 0..29, byte 29 being the settle selects
  function automatic logic [7:0] crc8(input logic [7:0] pll);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 30; i++) begin
      r = r ^ ((i == 29) ? pll : host.live[i]);
      for (int k = 0; k < 8; k++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot;
    rr(`NVMC_OFS_CTL);
    check(d & 8'hDF, 8'h10);
    rr(7'h7F);
    check(d, 8'h00);
    host.wr(`NVMC_OFS_PLLCFG, 8'h06);
    rr(`NVMC_OFS_PLLCFG);
    check(d, 8'h06);
    check({4'h0, closedLoopSettleSel, vcoSettleSel}, 8'h06);
    $display("boot test done");
  endtask
  task automatic t_settle;
    int e;
    for (int k = 0; k < 4; k++) begin
      host.wr(`NVMC_OFS_PLLCFG, {4'h0, 2'(3 - k), 2'(k)});
      @(negedge clk);
      pllCalStart = 1'b1;
      @(negedge clk);
      pllCalStart = 1'b0;
      e = (VUS[k] + CUS[3 - k]) * CPU;
      n = 1;
      while (pllSettleDone !== 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      check({7'h00, n >= e && n <= e + 6}, 8'h01);
    end
    $display("settle test done");
  endtask
  task automatic t_locked;
    host.wr(`NVMC_OFS_CTL, 8'h13);
    check({7'h00, arrayBusy}, 8'h00);
    host.wr(`NVMC_OFS_UNLK, ~KEY);
    host.wr(`NVMC_OFS_CTL, 8'h12);
    check({7'h00, arrayBusy}, 8'h00);
    host.wr(`NVMC_OFS_UNLK, KEY);
    host.wr(`NVMC_OFS_PLLCFG, 8'h09);
    host.wr(`NVMC_OFS_CTL, 8'h11);
    rr(`NVMC_OFS_CTL);
    check(d & 8'hDF, 8'h10);
    $display("locked test done");
  endtask
  task automatic t_program;
    for (int i = 0; i < 32; i++) host.live[i] = 8'(i * 7 + 3);
    host.wr(`NVMC_OFS_CTL, 8'h50);
    repeat (40) @(negedge clk);
    host.unlock_and_start(8'h13);
    check({7'h00, arrayBusy}, 8'h01);
    rr(`NVMC_OFS_CTL);
    check(d & 8'hDF, 8'h17);
    wait_idle();
    check({7'h00, n >= 2 * XUS * CPU}, 8'h01);
    rr(`NVMC_OFS_CNT);
    check(d, 8'h01);
    host.unlock_and_start(8'h11);
    wait_idle();
    rr(`NVMC_OFS_CNT);
    check(d, 8'h02);
    $display("program test done");
  endtask
  task automatic t_load;
    for (int i = 0; i < 29; i++) host.live[i] = 8'h00;
    host.wr(`NVMC_OFS_PLLCFG, 8'h00);
    host.wr(`NVMC_OFS_CTL, 8'h18);
    host.rd(`NVMC_OFS_CNT, 1'b0, d, ok);
    check({7'h00, ok}, 8'h00);
    rr(`NVMC_OFS_CTL);
    check(d, 8'h10);
    check(host.live[5], 8'h26);
    check({4'h0, closedLoopSettleSel, vcoSettleSel}, 8'h09);
    rr(`NVMC_OFS_SCRC);
    check(d, crc8(8'h09));
    // stale stored crc: change a byte, copy, program with auto crc off
    host.live[0] = 8'hFF;
    host.wr(`NVMC_OFS_CTL, 8'h40);
    repeat (40) @(negedge clk);
    host.unlock_and_start(8'h03);
    wait_idle();
    host.wr(`NVMC_OFS_CTL, 8'h08);
    rr(`NVMC_OFS_CTL);
    check(d, 8'h20);
    $display("load test done");
  endtask
  task automatic t_copy;
    host.wr(`NVMC_OFS_CTL, 8'h50);
    rr(`NVMC_OFS_CTL);
    check(d, 8'h70);
    repeat (40) @(negedge clk);
    rr(`NVMC_OFS_CTL);
    check(d, 8'h30);
    $display("copy test done");
  endtask
  task automatic t_saturate;
    rr(`NVMC_OFS_CNT);
    check(d, 8'h03);
    for (int i = 0; i < 256; i++) begin
      host.unlock_and_start(8'h11);
      wait_idle();
    end
    rr(`NVMC_OFS_CNT);
    check(d, 8'hFF);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rr(`NVMC_OFS_CNT);
    check(d, 8'hFF);
    $display("saturate test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    pllCalStart = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_boot();
    t_settle();
    t_locked();
    t_program();
    t_load();
    t_copy();
    t_saturate();
    tally_and_finish();
  end
  // about 256 short cycles of some 60 clocks each, plus margin
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
